// ### include/ltp_params.svh
// register map, field positions, reset values and timing of the protection block
`ifndef LTP_PARAMS_SVH
`define LTP_PARAMS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define LTP_ADDR_CTRL    8'h00
`define LTP_ADDR_OCL_CFG 8'h04
`define LTP_ADDR_OCL_THR 8'h08
`define LTP_ADDR_SCL_CFG 8'h0c
`define LTP_ADDR_SCL_THR 8'h10
`define LTP_ADDR_OTC_CFG 8'h14
`define LTP_ADDR_OTD_CFG 8'h18
`define LTP_ADDR_OTF_CFG 8'h1c
`define LTP_ADDR_STATUS  8'h20

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define LTP_CTRL_OC_REC_EN 0
`define LTP_CTRL_SC_REC_EN 1
`define LTP_CTRL_REC_TIME  8
`define LTP_FLD_LIMIT      0
`define LTP_FLD_DELAY      8
`define LTP_FLD_RECOV      16
`define LTP_STAT_OC_CNT    8
`define LTP_STAT_SC_CNT    16

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define LTP_RST_REC_TIME   8'h03
`define LTP_RST_LATCH_LIM  8'h00
`define LTP_RST_DEC_DELAY  8'h0a
`define LTP_RST_LATCH_REC  8'h0f
`define LTP_RST_LATCH_THR  16'h00c8
`define LTP_RST_OTC_THR    8'h37
`define LTP_RST_OTC_REC    8'h32
`define LTP_RST_OTD_THR    8'h3c
`define LTP_RST_OTD_REC    8'h37
`define LTP_RST_OTF_THR    8'h50
`define LTP_RST_OTF_REC    8'h41
`define LTP_RST_OT_DELAY   8'h02

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define LTP_TICK_S  1
`define LTP_CLK_HZ  100000000

`endif

// ### include/ltp_pkg.sv
// types shared by the protection block modules
package ltp_pkg;

  // protection state, one-hot
  typedef enum logic [1:0] {
    LTP_PROT_IDLE   = 2'b01,
    LTP_PROT_ACTIVE = 2'b10
  } ltp_prot_state_t;

  typedef struct packed {
    logic [7:0] secs;
  } ltp_qual_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] secs;
  } ltp_latch_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [1:0][31:0] latch_cfg;
    logic [1:0][15:0] latch_thr;
    logic [2:0][31:0] ot_cfg;
    logic [31:0] presc;
    logic tick;
    ltp_prot_state_t [4:0] prot;
  } ltp_top_state_t;

endpackage

// ### verilog/ltp_qual.sv
// seconds qualifier: reports a condition held for a number of ticks
module ltp_qual
  import ltp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cond_i,
  input wire logic tick_i,
  input wire logic [7:0] limit_i,
  output logic met_o
);

  ltp_qual_state_t q;
  ltp_qual_state_t next_q;

  // ---------------------------------------------------------------------------
  // seconds counter
  // ---------------------------------------------------------------------------
  // count whole seconds while the condition holds, saturating
  always_comb begin
    next_q = q;
    if (rst_i) begin
      next_q.secs = 8'h00;
    end else if (!cond_i) begin
      next_q.secs = 8'h00;
    end else if (tick_i && q.secs != 8'hff) begin
      next_q.secs = q.secs + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    q <= next_q;
  end

  assign met_o = cond_i && (q.secs >= limit_i);

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_qual_restart;
    @(posedge ref_clk_i) disable iff (rst_i)
    !cond_i |=> (q.secs == 8'h00);
  endproperty
  a_qual_restart: assert property (p_qual_restart)
    else $error("qualifier did not restart when condition dropped");

endmodule // ltp_qual

// ### verilog/ltp_latch_cnt.sv
// latch counter: counts fault events and decays once per delay
module ltp_latch_cnt
  import ltp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic event_i,
  input wire logic tick_i,
  input wire logic [7:0] dec_delay_i,
  input wire logic [7:0] limit_i,
  output logic [7:0] count_o,
  output logic reached_o
);

  ltp_latch_state_t q;
  ltp_latch_state_t next_q;
  logic dec_due;

  // ---------------------------------------------------------------------------
  // counter and decay timer
  // ---------------------------------------------------------------------------
  // a zero delay decays on every tick
  assign dec_due = (q.cnt != 8'h00) && tick_i &&
                   (({1'b0, q.secs} + 9'h001) >= {1'b0, dec_delay_i});

  always_comb begin
    next_q = q;
    if (rst_i) begin
      next_q = '0;
    end else begin
      if (event_i && !dec_due && q.cnt != 8'hff) begin
        next_q.cnt = q.cnt + 8'h01;
      end else if (!event_i && dec_due) begin
        next_q.cnt = q.cnt - 8'h01;
      end
      if (q.cnt == 8'h00 || dec_due) begin
        next_q.secs = 8'h00;
      end else if (tick_i && q.secs != 8'hff) begin
        next_q.secs = q.secs + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    q <= next_q;
  end

  assign count_o = q.cnt;
  // a zero limit leaves the latch protection off
  assign reached_o = (limit_i != 8'h00) && (q.cnt >= limit_i);

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_latch_inc;
    @(posedge ref_clk_i) disable iff (rst_i)
    (event_i && !dec_due && q.cnt != 8'hff) |=>
      (q.cnt == $past(q.cnt) + 8'h01);
  endproperty
  a_latch_inc: assert property (p_latch_inc)
    else $error("latch counter missed an increment");

  property p_latch_dec;
    @(posedge ref_clk_i) disable iff (rst_i)
    (dec_due && !event_i) |=> (q.cnt == $past(q.cnt) - 8'h01);
  endproperty
  a_latch_dec: assert property (p_latch_dec)
    else $error("latch counter missed a decrement");

endmodule // ltp_latch_cnt

// ### verilog/ltp_top.sv
// latch and temperature protection evaluation with wishbone registers
//
// Function
// - overcurrent events count up, decay per delay
// - short-circuit events count up, decay per delay
// - short-circuit latch trips at latch limit
// - overcurrent latch recovers on current above threshold
// - short-circuit latch recovers on current above threshold
// - charge overtemp trips at threshold after delay
// - charge overtemp recovers below threshold
// - charge overtemp ignores current flow
// - discharge overtemp trips at threshold after delay
// - discharge overtemp recovers below threshold
// - discharge overtemp ignores current flow
// - switch overtemp trips at threshold after delay
// - overcurrent latch trips at latch limit
// - one shared recovery time for the three overtemp channels, held continuously
// - switch overtemp recovers below threshold
//
// The address map and the Wishbone register port were decided locally.
`include "ltp_params.svh"

module ltp_top
  import ltp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `LTP_TICK_S * `LTP_CLK_HZ
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic signed [15:0] current_i,
  input wire logic signed [7:0] max_cell_temp_i,
  input wire logic [7:0] fet_temp_i,
  input wire logic discharge_overcurrent_i,
  input wire logic discharge_short_circuit_i,
  output logic discharge_overcurrent_latch_o,
  output logic short_circuit_latch_o,
  output logic charge_overtemp_o,
  output logic discharge_overtemp_o,
  output logic switch_overtemp_o
);

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  ltp_top_state_t q;
  ltp_top_state_t next_q;

  logic [1:0] fault_ev;
  logic [1:0][7:0] latch_cnt;
  logic [1:0] latch_reached;
  logic [1:0] cur_rec_met;
  logic [2:0] ot_trip_met;
  logic [2:0] ot_rec_met;
  logic [4:0] set_v;
  logic [4:0] clr_v;
  logic [4:0] active;
  logic [7:0] rec_time;
  logic bus_req;
  logic bus_wr;

  // merge written bytes into a register under the byte enables
  function automatic logic [31:0] ltp_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------------------
  // shared decodes
  // ---------------------------------------------------------------------------
  // request taken on first cycle, write lands on the ack edge
  assign bus_req = cyc_i && stb_i && !q.ack;
  assign bus_wr = cyc_i && stb_i && we_i && q.ack;
  assign rec_time = q.ctrl[`LTP_CTRL_REC_TIME +: 8];
  assign fault_ev = {discharge_short_circuit_i, discharge_overcurrent_i};

  // ---------------------------------------------------------------------------
  // latch counters and current recovery
  // ---------------------------------------------------------------------------
  for (genvar k = 0; k < 2; k++) begin : g_latch
    logic signed [15:0] thr;
    logic cur_cond;

    assign thr = q.latch_thr[k];
    assign cur_cond = q.ctrl[k] && (q.prot[k] == LTP_PROT_ACTIVE) &&
                      (current_i >= thr);

    ltp_latch_cnt u_cnt (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .event_i(fault_ev[k]),
      .tick_i(q.tick),
      .dec_delay_i(q.latch_cfg[k][`LTP_FLD_DELAY +: 8]),
      .limit_i(q.latch_cfg[k][`LTP_FLD_LIMIT +: 8]),
      .count_o(latch_cnt[k]),
      .reached_o(latch_reached[k])
    );

    ltp_qual u_rec (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .cond_i(cur_cond),
      .tick_i(q.tick),
      .limit_i(q.latch_cfg[k][`LTP_FLD_RECOV +: 8]),
      .met_o(cur_rec_met[k])
    );
  end

  // ---------------------------------------------------------------------------
  // temperature channels: charge, discharge, switch
  // ---------------------------------------------------------------------------
  for (genvar c = 0; c < 3; c++) begin : g_temp
    logic signed [8:0] temp;
    logic signed [8:0] thr;
    logic signed [8:0] rec;
    logic [7:0] thr_b;
    logic [7:0] rec_b;

    assign thr_b = q.ot_cfg[c][`LTP_FLD_LIMIT +: 8];
    assign rec_b = q.ot_cfg[c][`LTP_FLD_RECOV +: 8];
    // switch channel is unsigned, cell channels are signed
    if (c == 2) begin : g_uns
      assign temp = {1'b0, fet_temp_i};
      assign thr = {1'b0, thr_b};
      assign rec = {1'b0, rec_b};
    end else begin : g_sgn
      assign temp = {max_cell_temp_i[7], max_cell_temp_i};
      assign thr = {thr_b[7], thr_b};
      assign rec = {rec_b[7], rec_b};
    end

    ltp_qual u_trip (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .cond_i((q.prot[c+2] == LTP_PROT_IDLE) && (temp >= thr)),
      .tick_i(q.tick),
      .limit_i(q.ot_cfg[c][`LTP_FLD_DELAY +: 8]),
      .met_o(ot_trip_met[c])
    );

    ltp_qual u_rec (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .cond_i((q.prot[c+2] == LTP_PROT_ACTIVE) && (temp <= rec)),
      .tick_i(q.tick),
      .limit_i(rec_time),
      .met_o(ot_rec_met[c])
    );
  end

  assign set_v = {ot_trip_met, latch_reached};
  assign clr_v = {ot_rec_met, cur_rec_met};

  // ---------------------------------------------------------------------------
  // next state: tick, protections, register bus
  // ---------------------------------------------------------------------------
  always_comb begin
    next_q = q;
    if (rst_i) begin
      next_q = '0;
      next_q.ctrl[`LTP_CTRL_REC_TIME +: 8] = `LTP_RST_REC_TIME;
      for (int k = 0; k < 2; k++) begin
        next_q.latch_cfg[k] = {8'h00, `LTP_RST_LATCH_REC,
                               `LTP_RST_DEC_DELAY, `LTP_RST_LATCH_LIM};
        next_q.latch_thr[k] = `LTP_RST_LATCH_THR;
      end
      next_q.ot_cfg[0] = {8'h00, `LTP_RST_OTC_REC, `LTP_RST_OT_DELAY,
                          `LTP_RST_OTC_THR};
      next_q.ot_cfg[1] = {8'h00, `LTP_RST_OTD_REC, `LTP_RST_OT_DELAY,
                          `LTP_RST_OTD_THR};
      next_q.ot_cfg[2] = {8'h00, `LTP_RST_OTF_REC, `LTP_RST_OT_DELAY,
                          `LTP_RST_OTF_THR};
      for (int p = 0; p < 5; p++) begin
        next_q.prot[p] = LTP_PROT_IDLE;
      end
    end else begin
      next_q.tick = (q.presc >= TICK_LAST);
      next_q.presc = (q.presc >= TICK_LAST) ? 32'h0000_0000 :
                     q.presc + 32'h0000_0001;
      // trip wins over a recovery in the same cycle
      for (int p = 0; p < 5; p++) begin
        if (set_v[p]) begin
          next_q.prot[p] = LTP_PROT_ACTIVE;
        end else if (clr_v[p]) begin
          next_q.prot[p] = LTP_PROT_IDLE;
        end else begin
          next_q.prot[p] = q.prot[p];
        end
      end
      // single-cycle wishbone answer
      next_q.ack = bus_req;
      if (bus_req) begin
        case (adr_i)
          `LTP_ADDR_CTRL: next_q.rdata = {16'h0000, q.ctrl[15:8], 6'h00,
                                          q.ctrl[1:0]};
          `LTP_ADDR_OCL_CFG: next_q.rdata = q.latch_cfg[0];
          `LTP_ADDR_OCL_THR: next_q.rdata = {16'h0000, q.latch_thr[0]};
          `LTP_ADDR_SCL_CFG: next_q.rdata = q.latch_cfg[1];
          `LTP_ADDR_SCL_THR: next_q.rdata = {16'h0000, q.latch_thr[1]};
          `LTP_ADDR_OTC_CFG: next_q.rdata = q.ot_cfg[0];
          `LTP_ADDR_OTD_CFG: next_q.rdata = q.ot_cfg[1];
          `LTP_ADDR_OTF_CFG: next_q.rdata = q.ot_cfg[2];
          `LTP_ADDR_STATUS: next_q.rdata = {8'h00, latch_cnt[1],
                                            latch_cnt[0], 3'b000, active};
          default: next_q.rdata = 32'h0000_0000;
        endcase
      end
      if (bus_wr) begin
        case (adr_i)
          `LTP_ADDR_CTRL: begin
            next_q.ctrl = ltp_merge(q.ctrl, dat_i, sel_i);
            next_q.ctrl[31:16] = 16'h0000;
            next_q.ctrl[7:2] = 6'h00;
          end
          `LTP_ADDR_OCL_CFG: begin
            next_q.latch_cfg[0] = ltp_merge(q.latch_cfg[0], dat_i, sel_i);
            next_q.latch_cfg[0][31:24] = 8'h00;
          end
          `LTP_ADDR_OCL_THR: begin
            next_q.latch_thr[0] =
              16'(ltp_merge({16'h0000, q.latch_thr[0]}, dat_i,
                            sel_i));
          end
          `LTP_ADDR_SCL_CFG: begin
            next_q.latch_cfg[1] = ltp_merge(q.latch_cfg[1], dat_i, sel_i);
            next_q.latch_cfg[1][31:24] = 8'h00;
          end
          `LTP_ADDR_SCL_THR: begin
            next_q.latch_thr[1] =
              16'(ltp_merge({16'h0000, q.latch_thr[1]}, dat_i,
                            sel_i));
          end
          `LTP_ADDR_OTC_CFG: begin
            next_q.ot_cfg[0] = ltp_merge(q.ot_cfg[0], dat_i, sel_i);
            next_q.ot_cfg[0][31:24] = 8'h00;
          end
          `LTP_ADDR_OTD_CFG: begin
            next_q.ot_cfg[1] = ltp_merge(q.ot_cfg[1], dat_i, sel_i);
            next_q.ot_cfg[1][31:24] = 8'h00;
          end
          `LTP_ADDR_OTF_CFG: begin
            next_q.ot_cfg[2] = ltp_merge(q.ot_cfg[2], dat_i, sel_i);
            next_q.ot_cfg[2][31:24] = 8'h00;
          end
          default: begin
            next_q.ctrl = q.ctrl; // read-only or unmapped
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    q <= next_q;
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  for (genvar p = 0; p < 5; p++) begin : g_act
    assign active[p] = (q.prot[p] == LTP_PROT_ACTIVE);
  end

  assign dat_o = q.rdata;
  assign ack_o = q.ack;
  assign discharge_overcurrent_latch_o = active[0];
  assign short_circuit_latch_o = active[1];
  assign charge_overtemp_o = active[2];
  assign discharge_overtemp_o = active[3];
  assign switch_overtemp_o = active[4];

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_bus_ack;
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack)
    else $error("bus answer not a single ack one cycle later");

  property p_tick_gap;
    q.tick |=> !q.tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("tick lasted more than one cycle");

  property p_oc_latch_trip;
    latch_reached[0] |=> discharge_overcurrent_latch_o;
  endproperty
  a_oc_latch_trip: assert property (p_oc_latch_trip)
    else $error("overcurrent latch did not trip at limit");

  property p_sc_latch_trip;
    latch_reached[1] |=> short_circuit_latch_o;
  endproperty
  a_sc_latch_trip: assert property (p_sc_latch_trip)
    else $error("short-circuit latch did not trip at limit");

  property p_oc_rec_gate;
    (!q.ctrl[`LTP_CTRL_OC_REC_EN] && discharge_overcurrent_latch_o)
      |=> discharge_overcurrent_latch_o;
  endproperty
  a_oc_rec_gate: assert property (p_oc_rec_gate)
    else $error("overcurrent latch recovered with recovery disabled");

  property p_sc_recover;
    (cur_rec_met[1] && !latch_reached[1]) |=> !short_circuit_latch_o;
  endproperty
  a_sc_recover: assert property (p_sc_recover)
    else $error("short-circuit latch did not recover on current");

  property p_otc_trip;
    (ot_trip_met[0] && !charge_overtemp_o) |=> charge_overtemp_o;
  endproperty
  a_otc_trip: assert property (p_otc_trip)
    else $error("charge overtemp did not trip");

  property p_otd_recover;
    (ot_rec_met[1] && !ot_trip_met[1]) |=> !discharge_overtemp_o;
  endproperty
  a_otd_recover: assert property (p_otd_recover)
    else $error("discharge overtemp did not recover");

  property p_otf_trip;
    (ot_trip_met[2] && !switch_overtemp_o) |=> switch_overtemp_o;
  endproperty
  a_otf_trip: assert property (p_otf_trip)
    else $error("switch overtemp did not trip");

  c_oc_latch: cover property ($rose(discharge_overcurrent_latch_o));
  c_sc_recover: cover property ($fell(short_circuit_latch_o));
  c_otc_cycle: cover property ($fell(charge_overtemp_o));
  c_otf_trip: cover property ($rose(switch_overtemp_o));

endmodule // ltp_top

// ### verification/ltp_bench.sv
// self-checking bench for the latch and temperature protection block
`include "ltp_params.svh"
`define LTPB_CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; $display("ERROR %s expected %h seen %h", nm, e, g); end end

module latch_and_temp_protection_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] adr; logic [31:0] val;} ltp_row_t;
  logic ref_clk_i, rst_i, cyc_i, stb_i, we_i;
  logic [7:0] adr_i;
  logic [31:0] dat_i;
  logic [3:0] sel_i;
  logic [31:0] dat_o;
  logic ack_o;
  logic signed [15:0] cur_i;
  logic signed [7:0] cell_i;
  logic [7:0] fet_i;
  logic [1:0] ev;
  logic [4:0] prot; // {switch, discharge, charge, short, overcurrent}
  logic [31:0] q;
  int fail_count = 0;
  int n_compared = 0;
  // register reset values, plus one unmapped place
  ltp_row_t rows [10] = '{'{`LTP_ADDR_CTRL, 32'h00000300},
    '{`LTP_ADDR_OCL_CFG, 32'h000f0a00}, '{`LTP_ADDR_OCL_THR, 32'h000000c8},
    '{`LTP_ADDR_SCL_CFG, 32'h000f0a00}, '{`LTP_ADDR_SCL_THR, 32'h000000c8},
    '{`LTP_ADDR_OTC_CFG, 32'h00320237}, '{`LTP_ADDR_OTD_CFG, 32'h0037023c},
    '{`LTP_ADDR_OTF_CFG, 32'h00410250}, '{`LTP_ADDR_STATUS, 32'h00000000},
    '{8'h24, 32'h00000000}};

  ltp_top #(.TICK_CYCLES(10)) ltp_top_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .dat_o(dat_o), .ack_o(ack_o), .current_i(cur_i),
    .max_cell_temp_i(cell_i), .fet_temp_i(fet_i),
    .discharge_overcurrent_i(ev[0]), .discharge_short_circuit_i(ev[1]),
    .discharge_overcurrent_latch_o(prot[0]),
    .short_circuit_latch_o(prot[1]), .charge_overtemp_o(prot[2]),
    .discharge_overtemp_o(prot[3]), .switch_overtemp_o(prot[4]));

  // ----------------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    repeat (60000) @(posedge ref_clk_i);
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic give_verdict();
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one classic cycle, entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] rd);
    int i;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (ack_o === 1'b1) break;
    end
    if (i == 20) begin
      fail_count++;
      give_verdict();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic check_rows();
    foreach (rows[i]) begin
      wb(1'b0, rows[i].adr, 32'h0, q);
      `LTPB_CHK("reg_reset", rows[i].val, q)
    end
  endtask

  task automatic wait_out(input int k, input logic v, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      if (prot[k] === v) break;
      @(posedge ref_clk_i);
    end
    if (prot[k] !== v) begin
      fail_count++;
      give_verdict();
    end
  endtask

  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge ref_clk_i);
    ev[k] <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask

  // latch counter, trip at limit 2, decay, gated current recovery
  task automatic latch_test(input int k);
    logic [7:0] base;
    base = (k == 1) ? `LTP_ADDR_SCL_CFG : `LTP_ADDR_OCL_CFG;
    cur_i <= 16'sd0;
    wb(1'b1, base, 32'h00020a02, q); // decay above recovery
    pulse(k);
    wb(1'b0, `LTP_ADDR_STATUS, 32'h0, q);
    `LTPB_CHK("count_one", 8'h01, q[8*k+15 -: 8])
    `LTPB_CHK("below_limit", 1'b0, prot[k])
    pulse(k);
    `LTPB_CHK("at_limit", 1'b1, prot[k])
    cur_i <= 16'sd200;
    for (int n = 0; n < 60; n++) begin
      wb(1'b0, `LTP_ADDR_STATUS, 32'h0, q);
      if (q[8*k+15 -: 8] === 8'h01) break;
    end
    `LTPB_CHK("count_decay", 8'h01, q[8*k+15 -: 8])
    if (q[8*k+15 -: 8] !== 8'h01) give_verdict();
    `LTPB_CHK("rec_disabled", 1'b1, prot[k])
    cur_i <= 16'sd199;
    wb(1'b1, `LTP_ADDR_CTRL, 32'h00000300 | (32'h1 << k), q);
    repeat (50) @(posedge ref_clk_i);
    `LTPB_CHK("below_rec_thr", 1'b1, prot[k])
    cur_i <= 16'sd200;
    wait_out(k, 1'b0, 40);
    `LTPB_CHK("cur_recovered", 1'b0, prot[k])
    wb(1'b1, `LTP_ADDR_CTRL, 32'h00000300, q);
  endtask

  task automatic set_t(input int k, input logic [7:0] v);
    if (k == 4)
      fet_i <= v;
    else
      cell_i <= v;
  endtask

  // threshold, delay of 2 ticks, recovery over the shared 3 ticks
  task automatic ot_test(input int k, input logic [7:0] thr,
                         input logic [7:0] rec);
    set_t(k, thr - 8'h01);
    repeat (50) @(posedge ref_clk_i);
    `LTPB_CHK("below_thr", 1'b0, prot[k])
    set_t(k, thr);
    repeat (8) @(posedge ref_clk_i);
    `LTPB_CHK("early_trip", 1'b0, prot[k])
    wait_out(k, 1'b1, 30);
    `LTPB_CHK("tripped", 1'b1, prot[k])
    set_t(k, rec + 8'h01);
    repeat (50) @(posedge ref_clk_i);
    `LTPB_CHK("above_rec", 1'b1, prot[k])
    set_t(k, rec);
    repeat (15) @(posedge ref_clk_i);
    `LTPB_CHK("early_rec", 1'b1, prot[k])
    wait_out(k, 1'b0, 40);
    `LTPB_CHK("recovered", 1'b0, prot[k])
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i} = 3'b000;
    adr_i = 8'h00;
    dat_i = 32'h0;
    sel_i = 4'h0;
    cur_i = 16'sd0;
    cell_i = 8'sd25;
    fet_i = 8'h19;
    ev = 2'b00;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    `LTPB_CHK("reset_out", 5'h00, prot)
    check_rows();
    latch_test(0);
    latch_test(1);
    // cell channels trip while current flows the other way
    cur_i <= -16'sd1000;
    ot_test(2, 8'h37, 8'h32);
    ot_test(3, 8'h3c, 8'h37);
    ot_test(4, 8'h50, 8'h41);
    wb(1'b1, `LTP_ADDR_CTRL, 32'hffffffff, q);
    wb(1'b0, `LTP_ADDR_CTRL, 32'h0, q);
    `LTPB_CHK("ctrl_rsvd", 32'h0000ff03, q)
    // charge overtemp still held at 55, above its recovery point
    `LTPB_CHK("chg_held", 1'b1, prot[2])
    cell_i <= 8'sd25;
    rst_i <= 1'b1;
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    `LTPB_CHK("rerst_out", 5'h00, prot)
    check_rows();
    give_verdict();
  end
endmodule // latch_and_temp_protection_bench
